// ==== tbg_div16.sv ====
// Divide-by-16 stage from baud ticks to bit-rate ticks
`timescale 1ns/1ps
`default_nettype none
module tbg_div16
   import tbg_pkg::*;
#(
   parameter int DIV = TBG_SER_DIV
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Tick in and divided tick out
   input wire logic tick_in,
   output var logic tick_out
);

   localparam int W = $clog2(DIV);

   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic out;
   } tbg_div_st_t;

   tbg_div_st_t st_q;
   tbg_div_st_t st_d;

   // Count ticks, pulse on the last of each group
   always_comb
   begin
      st_d = st_q;
      st_d.out = 1'b0;
      if (tick_in)
      begin
         st_d.cnt = st_q.cnt + W'(1);
         if (st_q.cnt == W'(DIV - 1))
         begin
            st_d.cnt = '0;
            st_d.out = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign tick_out = st_q.out;

endmodule

`default_nettype wire

// ==== tbg_far_side.sv ====
// Far-side model: other timer's ticks and receiver stop-bit events
`timescale 1ns/1ps
`default_nettype none
module tbg_far_side
#(
   parameter int PER = 10
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench request and events out
   input wire logic stop_req,
   output var logic other_tick,
   output var logic rx_stop_bad
);
   int cnt;
   // Free-running other timer, one pulse per period
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt <= 0;
         other_tick <= 1'b0;
         rx_stop_bad <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
         other_tick <= (cnt == PER - 1);
         rx_stop_bad <= stop_req;
      end
   end
endmodule
`default_nettype wire

// ==== tbg_pkg.sv ====
// Package for the timer baud-rate generator: offsets, fields, types
`default_nettype none
package tbg_pkg;

   // APB byte offsets
   localparam logic [7:0] TBG_OFF_CTRL = 8'h00;  // timer_control_reg
   localparam logic [7:0] TBG_OFF_MODE = 8'h04;  // timer_mode_reg
   localparam logic [7:0] TBG_OFF_CNTL = 8'h08;  // count_low_byte
   localparam logic [7:0] TBG_OFF_CNTH = 8'h0C;  // count_high_byte
   localparam logic [7:0] TBG_OFF_RLDL = 8'h10;  // reload_low_byte
   localparam logic [7:0] TBG_OFF_RLDH = 8'h14;  // reload_high_byte
   localparam logic [7:0] TBG_OFF_SERIAL_CONTROL_REG = 8'h18;  // serial_control_reg
   localparam logic [7:0] TBG_OFF_POWER_CONTROL_REG = 8'h1C;  // power_control_reg

   // timer_control_reg fields
   localparam int TBG_B_OVF = 7;
   localparam int TBG_B_EXF = 6;
   localparam int TBG_B_RCLK = 5;
   localparam int TBG_B_TX_CLOCK_SOURCE_SEL = 4;
   localparam int TBG_B_EXEN = 3;
   localparam int TBG_B_RUN = 2;
   localparam int TBG_B_CSEL = 1;
   localparam int TBG_B_CPRL = 0;
   // serial_control_reg bit 7, power_control_reg bit 6
   localparam int TBG_B_SC7 = 7;
   localparam int TBG_B_FSEL = 6;

   // Reset values and counter maximum
   localparam logic [7:0] TBG_RST_BYTE = 8'h00;
   localparam logic [15:0] TBG_RST_WORD = 16'h0000;
   localparam logic [15:0] TBG_CNT_MAX = 16'hFFFF;
   // Oversampling divider of the serial side
   localparam int TBG_SER_DIV = 16;

   // Prescaler phase: one state time is two oscillator clocks
   typedef enum logic [0:0]
   {
      TBG_PH_A = 1'b0,
      TBG_PH_B = 1'b1
   } tbg_phase_t;

   // Bus request carried as one bundle
   typedef struct packed
   {
      logic sel;
      logic en;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } tbg_apb_req_t;

   // Serial-facing outputs
   typedef struct packed
   {
      logic tx_tick;
      logic rx_tick;
      logic tx_bit_tick;
      logic rx_bit_tick;
   } tbg_ticks_t;

endpackage

`default_nettype wire

// ==== tbg_top.sv ====
// Timer baud-rate generator with serial framing flag and APB registers
`timescale 1ns/1ps
`default_nettype none
module tbg_top
   import tbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output var logic pready,
   output var logic pslverr,
   // External pins
   input wire logic ext_count_pin,
   input wire logic ext_trigger_pin,
   // Other timer's baud ticks
   input wire logic other_tick,
   // Receiver stop-bit error event
   input wire logic rx_stop_bad,
   // Serial clock outputs
   output var logic tx_baud_tick,
   output var logic rx_baud_tick,
   output var logic tx_bit_tick,
   output var logic rx_bit_tick,
   // Overflow or external-edge flag interrupt request
   output var logic timer_irq
);

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [1:0] mode;
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [7:0] serial_control_reg;
      logic [7:0] power_control_reg;
      logic fe;
      tbg_phase_t ph;
      logic cnt_pin;
      logic trg_pin;
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic tx_t;
      logic rx_t;
      logic irq;
   } tbg_st_t;

   tbg_st_t st_q;
   tbg_st_t st_d;
   tbg_apb_req_t req;
   tbg_ticks_t div_tk;

   // Known register address
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == TBG_OFF_CTRL) || (a == TBG_OFF_MODE) ||
                (a == TBG_OFF_CNTL) || (a == TBG_OFF_CNTH) ||
                (a == TBG_OFF_RLDL) || (a == TBG_OFF_RLDH) ||
                (a == TBG_OFF_SERIAL_CONTROL_REG) || (a == TBG_OFF_POWER_CONTROL_REG);
   endfunction

   always_comb
   begin
      req.sel = psel;
      req.en = penable;
      req.wr = pwrite;
      req.addr = paddr;
      req.wdata = pwdata;
   end

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic baud;
      logic tick;
      logic roll;
      logic trg_fall;
      logic acc;
      logic wr;
      logic [7:0] sc7;
      baud = 1'b0;
      tick = 1'b0;
      roll = 1'b0;
      trg_fall = 1'b0;
      acc = 1'b0;
      wr = 1'b0;
      sc7 = 8'h00;
      st_d = st_q;
      st_d.rdy = 1'b0;
      st_d.err = 1'b0;
      st_d.tx_t = 1'b0;
      st_d.rx_t = 1'b0;
      st_d.cnt_pin = ext_count_pin;
      st_d.trg_pin = ext_trigger_pin;

      baud = st_q.ctrl[TBG_B_RCLK] | st_q.ctrl[TBG_B_TX_CLOCK_SOURCE_SEL];

      if (st_q.ctrl[TBG_B_RUN])
         st_d.ph = (st_q.ph == TBG_PH_A) ? TBG_PH_B : TBG_PH_A;

      // count pin falling edges as source
      if (st_q.ctrl[TBG_B_CSEL])
         tick = st_q.cnt_pin & ~ext_count_pin;
      else
         tick = baud ? (st_q.ph == TBG_PH_B) : 1'b0;

      tick = tick & st_q.ctrl[TBG_B_RUN];
      roll = tick && (st_q.cnt == TBG_CNT_MAX);

      if (tick)
         st_d.cnt = roll ? st_q.rld : st_q.cnt + 16'h0001;

      st_d.tx_t = st_q.ctrl[TBG_B_TX_CLOCK_SOURCE_SEL] ? roll : other_tick;
      st_d.rx_t = st_q.ctrl[TBG_B_RCLK] ? roll : other_tick;

      trg_fall = st_q.trg_pin & ~ext_trigger_pin & st_q.ctrl[TBG_B_EXEN];

      // Bus access phase, answered after one wait state
      acc = req.sel && req.en && !st_q.rdy;
      // Write lands at the edge that completes the transfer
      wr = req.sel && req.en && st_q.rdy && req.wr && addr_ok(req.addr);
      if (acc)
      begin
         st_d.rdy = 1'b1;
         st_d.err = !addr_ok(req.addr);
         sc7 = st_q.serial_control_reg;
         // bit 7 view depends on function select
         if (st_q.power_control_reg[TBG_B_FSEL])
            sc7[TBG_B_SC7] = st_q.fe;
         if (req.addr == TBG_OFF_CTRL)
            st_d.rdata = {24'h000000, st_q.ctrl};
         else if (req.addr == TBG_OFF_MODE)
            st_d.rdata = {30'h00000000, st_q.mode};
         else if (req.addr == TBG_OFF_CNTL)
            st_d.rdata = {24'h000000, st_q.cnt[7:0]};
         else if (req.addr == TBG_OFF_CNTH)
            st_d.rdata = {24'h000000, st_q.cnt[15:8]};
         else if (req.addr == TBG_OFF_RLDL)
            st_d.rdata = {24'h000000, st_q.rld[7:0]};
         else if (req.addr == TBG_OFF_RLDH)
            st_d.rdata = {24'h000000, st_q.rld[15:8]};
         else if (req.addr == TBG_OFF_SERIAL_CONTROL_REG)
            st_d.rdata = {24'h000000, sc7};
         else if (req.addr == TBG_OFF_POWER_CONTROL_REG)
            st_d.rdata = {24'h000000, st_q.power_control_reg};
         else
            st_d.rdata = 32'h00000000;
      end

      // Register writes; hardware sets below take priority
      // No interlock: a count write while running races the increment
      if (wr)
      begin
         if (req.addr == TBG_OFF_CTRL)
            st_d.ctrl = req.wdata[7:0];
         else if (req.addr == TBG_OFF_MODE)
            st_d.mode = req.wdata[1:0];
         else if (req.addr == TBG_OFF_CNTL)
            st_d.cnt[7:0] = req.wdata[7:0];
         else if (req.addr == TBG_OFF_CNTH)
            st_d.cnt[15:8] = req.wdata[7:0];
         else if (req.addr == TBG_OFF_RLDL)
            st_d.rld[7:0] = req.wdata[7:0];
         else if (req.addr == TBG_OFF_RLDH)
            st_d.rld[15:8] = req.wdata[7:0];
         else if (req.addr == TBG_OFF_SERIAL_CONTROL_REG)
         begin
            // framing flag cleared only by software
            if (st_q.power_control_reg[TBG_B_FSEL])
            begin
               st_d.serial_control_reg[6:0] = req.wdata[6:0];
               st_d.fe = req.wdata[TBG_B_SC7];
            end
            else
               st_d.serial_control_reg = req.wdata[7:0];
         end
         else if (req.addr == TBG_OFF_POWER_CONTROL_REG)
            st_d.power_control_reg = req.wdata[7:0];
      end

      // Hardware flag sets win over same-cycle clears
      // overflow flag only outside baud mode
      if (roll && !baud)
         st_d.ctrl[TBG_B_OVF] = 1'b1;
      // edge flag set, no reload in baud mode
      if (trg_fall)
         st_d.ctrl[TBG_B_EXF] = 1'b1;
      // missing stop bit sets framing flag
      if (rx_stop_bad)
         st_d.fe = 1'b1;

      st_d.irq = st_d.ctrl[TBG_B_OVF] | st_d.ctrl[TBG_B_EXF];
   end

   ////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= '0;
         st_q.ph <= TBG_PH_A;
      end
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////
   // Bit-rate dividers, one per direction

   logic [1:0] dir_tick;
   logic [1:0] dir_bit;

   // Index 0 is transmit, index 1 is receive
   assign dir_tick = {st_q.rx_t, st_q.tx_t};

   // bit rate is tick rate over 16
   for (genvar i = 0; i < 2; i++)
   begin : g_div
      tbg_div16 #(.DIV(TBG_SER_DIV)) u_div
      (
         .clk(clk),
         .rst(rst),
         .tick_in(dir_tick[i]),
         .tick_out(dir_bit[i])
      );
   end

   assign div_tk.tx_bit_tick = dir_bit[0];
   assign div_tk.rx_bit_tick = dir_bit[1];

   assign div_tk.tx_tick = st_q.tx_t;
   assign div_tk.rx_tick = st_q.rx_t;

   ////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops

   // Straight from the state and divider flip-flops
   assign tx_baud_tick = div_tk.tx_tick;
   assign rx_baud_tick = div_tk.rx_tick;
   assign tx_bit_tick = div_tk.tx_bit_tick;
   assign rx_bit_tick = div_tk.rx_bit_tick;
   assign prdata = st_q.rdata;
   assign pready = st_q.rdy;
   assign pslverr = st_q.err;
   assign timer_irq = st_q.irq;

endmodule

`default_nettype wire

// ==== tbg_top_chk_sva.sv ====
// Port-level assertion checker for the timer baud-rate generator
`timescale 1ns/1ps
`default_nettype none
module tbg_top_chk
   import tbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus and far-side inputs
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic other_tick,
   // Observed outputs
   input wire logic pready,
   input wire logic tx_baud_tick,
   input wire logic rx_baud_tick,
   input wire logic tx_bit_tick,
   input wire logic timer_irq
);
   logic [7:0] ctl_q;
   logic [7:0] ctl_p_q;
   logic [4:0] bt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
////////////////////////////////////////////////////////////////////////////
   // Control mirror; a one-cycle-old copy matches the tick latency
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl_q <= 8'h00;
         ctl_p_q <= 8'h00;
         bt_q <= 5'h00;
      end
      else
      begin
         if (psel && penable && pready && pwrite && paddr == TBG_OFF_CTRL)
            ctl_q <= pwdata[7:0];
         ctl_p_q <= ctl_q;
         bt_q <= tx_bit_tick ? 5'(tx_baud_tick) : bt_q + 5'(tx_baud_tick);
      end
   end
////////////////////////////////////////////////////////////////////////////
   property p_ans;
      psel && penable && !pready |=> pready;
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer missing");
   property p_one;
      pready |=> !pready;
   endproperty
   a_one: assert property (p_one) else $error("ready held too long");
   property p_tx_oth;
      !ctl_q[TBG_B_TX_CLOCK_SOURCE_SEL] && other_tick |=> tx_baud_tick;
   endproperty
   a_tx_oth: assert property (p_tx_oth) else $error("tx source wrong");
   property p_rx_oth;
      !ctl_q[TBG_B_RCLK] && other_tick |=> rx_baud_tick;
   endproperty
   a_rx_oth: assert property (p_rx_oth) else $error("rx source wrong");
   property p_pulse;
      tx_baud_tick |=> !tx_baud_tick;
   endproperty
   a_pulse: assert property (p_pulse) else $error("tick too long");
   property p_no_ovf;
      $rose(timer_irq) |->
         ctl_p_q[TBG_B_EXEN] || !(ctl_p_q[TBG_B_RCLK] || ctl_p_q[TBG_B_TX_CLOCK_SOURCE_SEL]);
   endproperty
   a_no_ovf: assert property (p_no_ovf) else $error("irq in baud mode");
   property p_hold;
      ctl_p_q[TBG_B_TX_CLOCK_SOURCE_SEL] && !ctl_p_q[TBG_B_RUN] && !$past(ctl_p_q[TBG_B_RUN])
         |-> !tx_baud_tick;
   endproperty
   a_hold: assert property (p_hold) else $error("tick while stopped");
   property p_bit;
      tx_bit_tick |-> bt_q == 5'h10;
   endproperty
   a_bit: assert property (p_bit) else $error("bit tick count wrong");
   c_bit: cover property (tx_bit_tick);
   c_irq: cover property ($rose(timer_irq));
   c_oth: cover property (other_tick && !ctl_q[TBG_B_TX_CLOCK_SOURCE_SEL]);
endmodule
bind tbg_top tbg_top_chk tbg_top_chk_inst (.clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .other_tick, .pready, .tx_baud_tick,
   .rx_baud_tick, .tx_bit_tick, .timer_irq);
`default_nettype wire

// ==== tbg_top_test.sv ====
// Self-checking bench for the timer baud-rate generator
`timescale 1ns/1ps
`default_nettype none
module tbg_top_test
   import tbg_pkg::*;
;
   localparam int OP = 10;
   logic clk, rst, psel, penable, pwrite, ext_trigger_pin, stop_req, perr;
   logic ext_count_pin;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, other_tick, rx_stop_bad, timer_irq;
   logic tx_baud_tick, rx_baud_tick, tx_bit_tick, rx_bit_tick;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   int rl;
   int m;
   int ntk = 0;
   logic [7:0] cfg [3] = '{8'h34, 8'h24, 8'h14};
   tbg_top tbg_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ext_count_pin,
      .ext_trigger_pin, .other_tick, .rx_stop_bad, .tx_baud_tick,
      .rx_baud_tick, .tx_bit_tick, .rx_bit_tick, .timer_irq);
   tbg_far_side #(.PER(OP)) tbg_far_side_inst (.clk, .rst, .stop_req,
      .other_tick, .rx_stop_bad);
////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One bus transfer; answer taken at the edge that sees ready
   task automatic apb(input bit w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      q = prdata;
      perr = pslverr;
      // A missing answer counts against the run
      if (pready !== 1'b1)
         chk(32'(pready), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   function automatic bit pick(input int s);
      return s == 0 ? tx_baud_tick : s == 1 ? rx_baud_tick :
             s == 2 ? tx_bit_tick : rx_bit_tick;
   endfunction
   // Reference tick period in clocks for one direction
   function automatic int pe(input bit sel, input int r);
      return sel ? 2 * (65536 - r) : OP;
   endfunction
   // Clocks between two ticks; bounded so a dead output cannot hang
   task automatic meas(input int s, output int p);
      int k;
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (!pick(s) && k < 3000);
      p = 0;
      do
      begin
         @(negedge clk);
         p++;
      end
      while (!pick(s) && p < 3000);
   endtask
   task automatic trig();
      ext_trigger_pin <= 1'b0;
      repeat (4) @(posedge clk);
      ext_trigger_pin <= 1'b1;
   endtask
   // Falling edges on the count pin, one every two clocks
   task automatic pulse_cnt(input int c);
      repeat (c)
      begin
         ext_count_pin <= 1'b0;
         @(posedge clk);
         ext_count_pin <= 1'b1;
         @(posedge clk);
      end
   endtask
////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      // Transmit baud ticks seen, for the pin-count scenario
      if (tx_baud_tick === 1'b1)
         ntk++;
      if (cyc == 20000)
      begin
         num_errors++;
         print_verdict();
      end
   end
   // Main sequence
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_trigger_pin = 1'b1;
      ext_count_pin = 1'b1;
      stop_req = 1'b0;
      void'($urandom(2337));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(TBG_OFF_CTRL, 32'h0);
      rd(8'h20, 32'h0);
      chk(32'(perr), 32'h1);
      foreach (cfg[i])
      begin
         rl = 32'hFFF0 | ($urandom % 16);
         wr(TBG_OFF_CTRL, 32'h0);
         wr(TBG_OFF_RLDL, rl & 255);
         wr(TBG_OFF_RLDH, 32'hFF);
         wr(TBG_OFF_CNTL, rl & 255);
         wr(TBG_OFF_CNTH, 32'hFF);
         wr(TBG_OFF_CTRL, 32'(cfg[i]));
         meas(0, n);
         chk(n, pe(cfg[i][4], rl));
         meas(1, n);
         chk(n, pe(cfg[i][5], rl));
         meas(2, n);
         chk(n, 16 * pe(cfg[i][4], rl));
         meas(3, n);
         chk(n, 16 * pe(cfg[i][5], rl));
         rd(TBG_OFF_RLDL, rl & 255);
         rd(TBG_OFF_CTRL, 32'(cfg[i]));
      end
      // Baud mode clocked from the count pin
      wr(TBG_OFF_CTRL, 32'h0);
      wr(TBG_OFF_CNTL, rl & 255);
      wr(TBG_OFF_CNTH, 32'hFF);
      wr(TBG_OFF_CTRL, 32'h36);
      m = ntk;
      pulse_cnt(65535 - rl);
      repeat (2) @(posedge clk);
      chk(ntk - m, 32'h0);
      pulse_cnt(1);
      repeat (2) @(posedge clk);
      chk(ntk - m, 32'h1);
      // Outside baud mode: setup alone does not run
      wr(TBG_OFF_CTRL, 32'h0);
      wr(TBG_OFF_CNTL, 32'hFE);
      wr(TBG_OFF_CTRL, 32'h02);
      pulse_cnt(3);
      rd(TBG_OFF_CNTL, 32'hFE);
      wr(TBG_OFF_CTRL, 32'h06);
      pulse_cnt(2);
      repeat (2) @(posedge clk);
      rd(TBG_OFF_CTRL, 32'h86);
      chk(32'(timer_irq), 32'h1);
      wr(TBG_OFF_CTRL, 32'h3C);
      trig();
      rd(TBG_OFF_CTRL, 32'h7C);
      chk(32'(timer_irq), 32'h1);
      wr(TBG_OFF_CTRL, 32'h34);
      trig();
      rd(TBG_OFF_CTRL, 32'h34);
      chk(32'(timer_irq), 32'h0);
      wr(TBG_OFF_CTRL, 32'h30);
      wr(TBG_OFF_CNTL, 32'h5A);
      repeat (40) @(posedge clk);
      rd(TBG_OFF_CNTL, 32'h5A);
      wr(TBG_OFF_POWER_CONTROL_REG, 32'h40);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (3) @(posedge clk);
      rd(TBG_OFF_SERIAL_CONTROL_REG, 32'h80);
      repeat (8) @(posedge clk);
      rd(TBG_OFF_SERIAL_CONTROL_REG, 32'h80);
      wr(TBG_OFF_SERIAL_CONTROL_REG, 32'h0);
      rd(TBG_OFF_SERIAL_CONTROL_REG, 32'h0);
      wr(TBG_OFF_POWER_CONTROL_REG, 32'h0);
      wr(TBG_OFF_SERIAL_CONTROL_REG, 32'h80);
      rd(TBG_OFF_SERIAL_CONTROL_REG, 32'h80);
      print_verdict();
   end
endmodule
`default_nettype wire
